// ---- rtl/apt_tracker.sv ----
// Absolute position tracker for one servo axis with APB register access
// Encoder samples, feedback and in-position come from logic on clk_sys_i;
// amplifier power and battery/encoder status pins are asynchronous
`timescale 1ns/100ps
`include "apt_defs.svh"

// Function
// - Current value restored from encoder at power-up, no new home return.
// - Battery removal, battery error or encoder change invalidates absolute position.
// - Restored values outside signed 32-bit range are refused.
// - Restore ignores address shifts made by current value change.
// - No restore while home return is still required.
// - Encoder may move at most half a turn per 3.5 ms window.
// - Encoder data must match amplifier feedback position, else error.
// - History entry at system on, power off, home done and restore.
// - Each entry carries the month/day/hour/minute stamp.
// - Encoder value recorded as revolution count and within-turn position.
// - Home entry records encoder value when settled in position.
// - Recorded servo command equals last command sent to amplifier.
// - Monitor current value kept apart from feed value, no fault.
// - Failed restore writes an alarm code into the history entry.
// - Travel during power-off beyond configured limit raises an error.
// - Travel limit cannot be enabled for a linear amplifier.
module apt_tracker
   import apt_pkg::*;
#(
   parameter int HIST_DEPTH   = 8,
   parameter int CHECK_CYCLES = `APT_CHECK_CYCLES
) (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        enc_valid_i,
   input  wire apt_enc_s    enc_i,
   input  wire logic [31:0] fb_pos_i,
   input  wire logic        in_position_i,
   input  wire logic        amp_power_i,
   input  wire logic        battery_err_i,
   input  wire logic        battery_removed_i,
   input  wire logic        enc_replaced_i,
   output logic      [31:0] servo_cmd_o,
   output logic             motion_en_o,
   output logic             home_req_o,
   output logic             irq_o
);
   localparam int HW = $clog2(HIST_DEPTH);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [3:0] sync1_q;
   logic [3:0] sync2_q;
   logic       amp_prev_q;
   logic [2:0] lost_prev_q;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sync1_q     <= 4'h0;
         sync2_q     <= 4'h0;
         amp_prev_q  <= 1'b0;
         lost_prev_q <= 3'h0;
      end else begin
         sync1_q     <= {enc_replaced_i, battery_removed_i, battery_err_i, amp_power_i};
         sync2_q     <= sync1_q;
         amp_prev_q  <= sync2_q[0];
         lost_prev_q <= sync2_q[3:1];
      end
   end
   wire amp_rise = sync2_q[0] & ~amp_prev_q;
   wire amp_fall = ~sync2_q[0] & amp_prev_q;
   wire abs_lost = |(sync2_q[3:1] & ~lost_prev_q);

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   logic                pready_q;
   logic                pslverr_q;
   logic [31:0]         prdata_q;
   wire                 acc_phase = psel_i & penable_i;
   wire                 wr_go     = acc_phase & pready_q & pwrite_i;
   wire                 mapped    = (paddr_i[1:0] == 2'h0) && (paddr_i <= `APT_OFF_HIST_CNT);
   wire                 wr_ctrl   = wr_go && paddr_i == `APT_OFF_CTRL;
   wire                 wr_clr    = wr_go && paddr_i == `APT_OFF_IRQ_CLR;
   wire                 wr_en     = wr_go && paddr_i == `APT_OFF_IRQ_EN;
   wire                 wr_cmd    = wr_go && paddr_i == `APT_OFF_POS_CMD;
   wire                 wr_chg    = wr_go && paddr_i == `APT_OFF_CUR_CHG;
   wire                 wr_lim    = wr_go && paddr_i == `APT_OFF_TRAV_LIM;
   wire                 wr_clk    = wr_go && paddr_i == `APT_OFF_CLK_DATA;
   wire                 wr_home   = wr_go && paddr_i == `APT_OFF_HOME_ADDR;
   wire                 wr_hsel   = wr_go && paddr_i == `APT_OFF_HIST_SEL;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   apt_state_e          state_q;
   apt_state_e          state_d;
   logic                abs_valid_q;
   logic                home_req_q;
   logic                linear_q;
   logic                trav_en_q;
   logic                boot_q;
   logic [31:0]         clk_data_q;
   logic [31:0]         stamp_q;
   logic [31:0]         trav_lim_q;
   logic [31:0]         home_addr_q;
   logic [31:0]         ref_enc_q;
   logic [31:0]         feed_q;
   logic [31:0]         chg_off_q;
   logic [31:0]         mon_q;
   logic [31:0]         enc_last_q;
   logic [31:0]         enc_off_q;
   logic [31:0]         enc_win_q;
   logic [$clog2(CHECK_CYCLES+1)-1:0] win_cnt_q;
   logic [`APT_IRQ_W-1:0] irq_stat_q;
   logic [`APT_IRQ_W-1:0] irq_en_q;
   logic                motion_en_q;
   logic [31:0]         servo_cmd_q;
   apt_hist_s           hist_mem [HIST_DEPTH];
   logic [HW-1:0]       hist_wp_q;
   logic [HW-1:0]       hist_sel_q;
   logic [HW:0]         hist_cnt_q;

   function automatic logic [31:0] abs_diff(input logic [31:0] a, input logic [31:0] b);
      logic [31:0] d;
      d = a - b;
      abs_diff = d[31] ? (32'h0 - d) : d;
   endfunction

   wire        [31:0] enc_abs  = enc_i;
   // Window base takes this cycle's sample when enc_valid_i is high, else the last valid sample held in enc_last_q
   wire        [31:0] enc_now  = enc_valid_i ? enc_abs : enc_last_q;
   wire               running  = state_q == ST_RUN || state_q == ST_HOMING;
   // 34-bit sum keeps overflow visible
   wire signed [33:0] restored = {{2{home_addr_q[31]}}, home_addr_q}
                               + {{2{enc_abs[31]}}, enc_abs} - {{2{ref_enc_q[31]}}, ref_enc_q};
   wire               in_range = restored[33:31] == 3'b000 || restored[33:31] == 3'b111;
   wire               trav_bad = trav_en_q && abs_diff(enc_abs, enc_off_q) > trav_lim_q;
   wire               rest_go  = state_q == ST_RESTORE && enc_valid_i;
   wire               rest_ok  = rest_go && abs_valid_q && in_range && !trav_bad;
   wire        [7:0]  rest_alm = !abs_valid_q ? `APT_ALM_HOMEREQ :
                                 !in_range    ? `APT_ALM_RANGE   :
                                 trav_bad     ? `APT_ALM_TRAVEL  : `APT_ALM_NONE;
   wire               home_go  = state_q == ST_HOMING && enc_valid_i && in_position_i;
   wire               spd_err  = running && enc_valid_i
                              && abs_diff(enc_abs, enc_win_q) > `APT_HALF_REV;
   wire               fb_err   = running && enc_valid_i && enc_abs != fb_pos_i;
   wire               win_end  = win_cnt_q == 0;
   // Motor-side pulses from the current feed, minus any current value change shift
   wire        [31:0] cmd_next = (wr_cmd ? pwdata_i : feed_q) - home_addr_q - chg_off_q + ref_enc_q;

   // ----------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      case (state_q)
         ST_OFF:     if (amp_rise) state_d = ST_RESTORE;
         ST_RESTORE: if (enc_valid_i) state_d = ST_RUN;
         ST_RUN:     if (wr_ctrl && pwdata_i[`APT_CTRL_HOME]) state_d = ST_HOMING;
         ST_HOMING:  if (home_go) state_d = ST_RUN;
         default:    state_d = ST_OFF;
      endcase
      if (amp_fall) state_d = ST_OFF;
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_q     <= ST_OFF;
         motion_en_q <= 1'b0;
      end else begin
         state_q     <= state_d;
         motion_en_q <= (state_d == ST_RUN || state_d == ST_HOMING);
      end
   end

   // Validity of the absolute reference
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         abs_valid_q <= 1'b0;
         home_req_q  <= 1'b1;
      end else if (abs_lost || (rest_go && trav_bad)) begin
         abs_valid_q <= 1'b0;
         home_req_q  <= 1'b1;
      end else if (home_go) begin
         abs_valid_q <= 1'b1;
         home_req_q  <= 1'b0;
      end
   end

   // Reference and current values
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ref_enc_q <= 32'h0;
         feed_q    <= 32'h0;
         chg_off_q <= 32'h0;
      end else if (home_go) begin
         ref_enc_q <= enc_abs;
         feed_q    <= home_addr_q;
         chg_off_q <= 32'h0;
      end else if (rest_ok) begin
         feed_q    <= restored[31:0];
         chg_off_q <= 32'h0;
      end else if (wr_chg) begin
         chg_off_q <= chg_off_q + (pwdata_i - feed_q);
         feed_q    <= pwdata_i;
      end else if (wr_cmd && abs_valid_q) begin
         feed_q    <= pwdata_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         servo_cmd_q <= 32'h0;
      end else if ((wr_cmd && abs_valid_q) || rest_ok) begin
         servo_cmd_q <= rest_ok ? enc_abs : cmd_next;
      end
   end

   // Monitor value follows the encoder and home reference, never the change offset
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         mon_q      <= 32'h0;
         enc_last_q <= 32'h0;
      end else if (enc_valid_i) begin
         mon_q      <= restored[31:0];
         enc_last_q <= enc_abs;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         enc_off_q <= 32'h0;
      end else if (amp_fall) begin
         enc_off_q <= enc_last_q;
      end
   end

   // Speed check window; restarts from the last sample each interval
   always_ff @(posedge clk_sys_i) begin
      if (reset_i || !running) begin
         win_cnt_q <= ($clog2(CHECK_CYCLES+1))'(CHECK_CYCLES - 1);
         enc_win_q <= enc_now;
      end else if (win_end) begin
         win_cnt_q <= ($clog2(CHECK_CYCLES+1))'(CHECK_CYCLES - 1);
         enc_win_q <= enc_now;
      end else begin
         win_cnt_q <= win_cnt_q - 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Configuration and clock data
   // ----------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         linear_q    <= 1'b0;
         trav_en_q   <= 1'b0;
         trav_lim_q  <= 32'h0;
         home_addr_q <= 32'h0;
         clk_data_q  <= 32'h0;
         stamp_q     <= 32'h0;
         hist_sel_q  <= '0;
      end else begin
         if (wr_ctrl) begin
            linear_q  <= pwdata_i[`APT_CTRL_LINEAR];
            trav_en_q <= pwdata_i[`APT_CTRL_TRAV_EN] & ~pwdata_i[`APT_CTRL_LINEAR];
         end
         if (wr_lim) trav_lim_q <= pwdata_i;
         if (wr_home) home_addr_q <= pwdata_i;
         if (wr_clk) clk_data_q <= pwdata_i;
         // Stamp only moves on request, so a half-written clock never leaks in
         if (wr_ctrl && pwdata_i[`APT_CTRL_CLKREQ]) stamp_q <= clk_data_q;
         if (wr_hsel) hist_sel_q <= pwdata_i[HW-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Current value history
   // ----------------------------------------------------------------
   wire       hist_we = boot_q || amp_fall || rest_go || home_go;
   apt_hist_s hist_new;
   always_comb begin
      hist_new       = '0;
      hist_new.stamp = stamp_q;
      hist_new.enc   = enc_valid_i ? enc_i : enc_last_q;
      hist_new.scmd  = servo_cmd_q;
      hist_new.mon   = mon_q;
      hist_new.kind  = boot_q ? EV_SYS_ON : amp_fall ? EV_AMP_OFF : rest_go ? EV_AMP_ON : EV_HOME;
      hist_new.alarm = rest_go ? rest_alm : `APT_ALM_NONE;
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         boot_q     <= 1'b1;
         hist_wp_q  <= '0;
         hist_cnt_q <= '0;
      end else begin
         boot_q <= 1'b0;
         if (hist_we) begin
            hist_wp_q  <= hist_wp_q + 1'b1;
            hist_cnt_q <= (hist_cnt_q == (HW+1)'(HIST_DEPTH)) ? hist_cnt_q : hist_cnt_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (hist_we) hist_mem[hist_wp_q] <= hist_new;
   end

   // ----------------------------------------------------------------
   // Interrupts
   // ----------------------------------------------------------------
   wire [`APT_IRQ_W-1:0] irq_ev = {abs_lost, home_go, rest_go && !rest_ok,
                                   rest_go && trav_bad, fb_err, spd_err};
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         irq_stat_q <= '0;
         irq_en_q   <= '0;
      end else begin
         // Set beats a clear in the same cycle
         irq_stat_q <= (irq_stat_q & ~(wr_clr ? pwdata_i[`APT_IRQ_W-1:0] : '0)) | irq_ev;
         if (wr_en) irq_en_q <= pwdata_i[`APT_IRQ_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // Read mux and answer
   // ----------------------------------------------------------------
   apt_hist_s   hist_rd;
   logic [31:0] rd_mux;
   assign hist_rd = hist_mem[hist_sel_q];
   always_comb begin
      case (paddr_i)
         `APT_OFF_CTRL:       rd_mux = {28'h0, trav_en_q, linear_q, 2'h0};
         `APT_OFF_STATUS:     rd_mux = {28'h0, motion_en_q, ~abs_valid_q, abs_valid_q, 1'b0};
         `APT_OFF_IRQ_STAT:   rd_mux = {26'h0, irq_stat_q};
         `APT_OFF_IRQ_EN:     rd_mux = {26'h0, irq_en_q};
         `APT_OFF_POS_CMD:    rd_mux = servo_cmd_q;
         `APT_OFF_TRAV_LIM:   rd_mux = trav_lim_q;
         `APT_OFF_CLK_DATA:   rd_mux = clk_data_q;
         `APT_OFF_FEED:       rd_mux = feed_q;
         `APT_OFF_MONITOR:    rd_mux = mon_q;
         `APT_OFF_HOME_ADDR:  rd_mux = home_addr_q;
         `APT_OFF_HIST_SEL:   rd_mux = 32'(hist_sel_q);
         `APT_OFF_HIST_STAMP: rd_mux = hist_rd.stamp;
         `APT_OFF_HIST_ENC:   rd_mux = hist_rd.enc;
         `APT_OFF_HIST_SCMD:  rd_mux = hist_rd.scmd;
         `APT_OFF_HIST_MON:   rd_mux = hist_rd.mon;
         `APT_OFF_HIST_INFO:  rd_mux = {22'h0, hist_rd.kind, hist_rd.alarm};
         `APT_OFF_HIST_CNT:   rd_mux = 32'(hist_cnt_q);
         default:             rd_mux = 32'h0;
      endcase
   end

   // One wait state: the answer comes on the second access cycle
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0;
      end else begin
         pready_q  <= acc_phase & ~pready_q;
         pslverr_q <= acc_phase & ~pready_q & ~mapped;
         prdata_q  <= (acc_phase & ~pready_q & ~pwrite_i) ? rd_mux : 32'h0;
      end
   end

   logic irq_q;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) irq_q <= 1'b0;
      else irq_q <= |(irq_stat_q & irq_en_q);
   end

   assign prdata_o    = prdata_q;
   assign pready_o    = pready_q;
   assign pslverr_o   = pslverr_q;
   assign servo_cmd_o = servo_cmd_q;
   assign motion_en_o = motion_en_q;
   assign home_req_o  = home_req_q;
   assign irq_o       = irq_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_linear_no_limit;
      @(posedge clk_sys_i) disable iff (reset_i) linear_q |-> !trav_en_q;
   endproperty
   a_linear_no_limit: assert property (p_linear_no_limit) else $error("travel limit on linear amp");

   property p_no_restore_homereq;
      @(posedge clk_sys_i) disable iff (reset_i)
         rest_go && !abs_valid_q |=> irq_stat_q[`APT_IRQ_RESTFAIL] && $stable(feed_q);
   endproperty
   a_no_restore_homereq: assert property (p_no_restore_homereq) else $error("restored without home");

   property p_range_fail;
      @(posedge clk_sys_i) disable iff (reset_i)
         rest_go && !in_range |=> irq_stat_q[`APT_IRQ_RESTFAIL] && $stable(feed_q);
   endproperty
   a_range_fail: assert property (p_range_fail) else $error("out of range value restored");

   property p_speed;
      @(posedge clk_sys_i) disable iff (reset_i)
         running && enc_valid_i && abs_diff(enc_abs, enc_win_q) > `APT_HALF_REV
         |=> irq_stat_q[`APT_IRQ_SPEED];
   endproperty
   a_speed: assert property (p_speed) else $error("speed error missed");

   property p_fb;
      @(posedge clk_sys_i) disable iff (reset_i)
         running && enc_valid_i && enc_abs != fb_pos_i |=> irq_stat_q[`APT_IRQ_FBMIS];
   endproperty
   a_fb: assert property (p_fb) else $error("feedback mismatch missed");

   property p_home_ref;
      @(posedge clk_sys_i) disable iff (reset_i)
         home_go |=> ref_enc_q == $past(enc_abs) && abs_valid_q && feed_q == home_addr_q;
   endproperty
   a_home_ref: assert property (p_home_ref) else $error("home reference wrong");

   property p_motion_after_restore;
      @(posedge clk_sys_i) disable iff (reset_i)
         $rose(motion_en_o) |-> $past(state_q) == ST_RESTORE;
   endproperty
   a_motion_after_restore: assert property (p_motion_after_restore) else $error("motion before restore");

   property p_abs_lost;
      @(posedge clk_sys_i) disable iff (reset_i) abs_lost |=> home_req_o;
   endproperty
   a_abs_lost: assert property (p_abs_lost) else $error("position not invalidated");

   property p_restore_value;
      @(posedge clk_sys_i) disable iff (reset_i)
         rest_ok |=> feed_q == $past(restored[31:0]) && chg_off_q == 32'h0;
   endproperty
   a_restore_value: assert property (p_restore_value) else $error("restored value wrong");

   property p_hist_stamp;
      @(posedge clk_sys_i) disable iff (reset_i)
         hist_we |=> hist_mem[$past(hist_wp_q)].stamp == $past(stamp_q);
   endproperty
   a_hist_stamp: assert property (p_hist_stamp) else $error("history stamp wrong");

   c_restore_ok:  cover property (@(posedge clk_sys_i) disable iff (reset_i) rest_ok);
   c_home_done:   cover property (@(posedge clk_sys_i) disable iff (reset_i) home_go);
   c_travel_fail: cover property (@(posedge clk_sys_i) disable iff (reset_i) rest_go && trav_bad);
endmodule

// ---- common/apt_defs.svh ----
// Register offsets, field positions, alarm codes and timing counts
// Assumes a 40 MHz system clock and a 32-bit APB slave port
`ifndef APT_DEFS_SVH
`define APT_DEFS_SVH
`define APT_OFF_CTRL       8'h00
`define APT_OFF_STATUS     8'h04
`define APT_OFF_IRQ_STAT   8'h08
`define APT_OFF_IRQ_CLR    8'h0c
`define APT_OFF_IRQ_EN     8'h10
`define APT_OFF_POS_CMD    8'h14
`define APT_OFF_CUR_CHG    8'h18
`define APT_OFF_TRAV_LIM   8'h1c
`define APT_OFF_CLK_DATA   8'h20
`define APT_OFF_FEED       8'h24
`define APT_OFF_MONITOR    8'h28
`define APT_OFF_HOME_ADDR  8'h2c
`define APT_OFF_HIST_SEL   8'h30
`define APT_OFF_HIST_STAMP 8'h34
`define APT_OFF_HIST_ENC   8'h38
`define APT_OFF_HIST_SCMD  8'h3c
`define APT_OFF_HIST_MON   8'h40
`define APT_OFF_HIST_INFO  8'h44
`define APT_OFF_HIST_CNT   8'h48
`define APT_CTRL_HOME      0
`define APT_CTRL_CLKREQ    1
`define APT_CTRL_LINEAR    2
`define APT_CTRL_TRAV_EN   3
`define APT_IRQ_SPEED      0
`define APT_IRQ_FBMIS      1
`define APT_IRQ_TRAVEL     2
`define APT_IRQ_RESTFAIL   3
`define APT_IRQ_HOMEDONE   4
`define APT_IRQ_ABSLOST    5
`define APT_IRQ_W          6
`define APT_ALM_NONE       8'h00
`define APT_ALM_HOMEREQ    8'h01
`define APT_ALM_RANGE      8'h02
`define APT_ALM_TRAVEL     8'h03
`define APT_HALF_REV       32'h0000_8000
`define APT_CHECK_PERIOD_NS 3500000
`define APT_CLK_PERIOD_NS   25
`define APT_CHECK_CYCLES    (`APT_CHECK_PERIOD_NS / `APT_CLK_PERIOD_NS)
`endif

// ---- common/apt_pkg.sv ----
// Types shared by the absolute position tracker
// Assumes a 16-bit revolution count and 16-bit within-revolution position
package apt_pkg;
   typedef struct packed {
      logic [15:0] multi;
      logic [15:0] spos;
   } apt_enc_s;

   typedef enum logic [1:0] {
      EV_SYS_ON,
      EV_AMP_OFF,
      EV_AMP_ON,
      EV_HOME
   } apt_kind_e;

   typedef struct packed {
      apt_kind_e   kind;
      logic [7:0]  alarm;
      logic [31:0] stamp;
      apt_enc_s    enc;
      logic [31:0] scmd;
      logic [31:0] mon;
   } apt_hist_s;

   typedef enum logic [1:0] {ST_OFF, ST_RESTORE, ST_RUN, ST_HOMING} apt_state_e;
endpackage

// ---- sim/apt_servo_model.sv ----
// Servo amplifier and encoder model for the tracker bench
// Assumes the bench sets position, power and feedback fault
`timescale 1ns/100ps
module apt_servo_model import apt_pkg::*; (
   input  wire logic        clk_sys_i,
   input  wire logic [31:0] pos_i,
   input  wire logic        power_i,
   input  wire logic        bad_fb_i,
   output logic             enc_valid_o,
   output apt_enc_s         enc_o,
   output logic      [31:0] fb_pos_o,
   output logic             in_position_o
);
   logic [1:0] div_q;
   initial begin
      div_q = 2'h0;
      enc_valid_o = 1'b0;
      enc_o = 32'h0;
      fb_pos_o = 32'h0;
   end
   assign in_position_o = power_i;
   // Unpowered lines toggle so stale data never looks valid
   always @(posedge clk_sys_i) begin
      div_q <= div_q + 2'h1;
      enc_valid_o <= power_i && div_q == 2'h3;
      enc_o <= power_i ? pos_i : ~enc_o;
      fb_pos_o <= power_i ? pos_i + {31'h0, bad_fb_i} : ~fb_pos_o;
   end
endmodule

// ---- sim/absolute_position_tracker_tb_top.sv ----
// Bench top: APB master, servo model and checks for the tracker
// Assumes APB answers come within twenty cycles
`timescale 1ns/100ps
`include "apt_defs.svh"
module absolute_position_tracker_tb_top import apt_pkg::*; ;
   logic        clk_sys_i = 1'b0, reset_i = 1'b1;
   logic        psel = 1'b0, pen = 1'b0, pwr = 1'b0, perr;
   logic [7:0]  pa = 8'h00;
   logic [31:0] pwd = 32'h0, pos = 32'h0010_0000, ha, rf, cmd;
   logic        pw_on = 1'b0, bad = 1'b0;
   logic [2:0]  lost = 3'h0;
   wire  [31:0] prdata_o, fb, servo_cmd_o;
   wire         pready_o, pslverr_o, ev, inp, motion_en_o, home_req_o, irq_o;
   apt_enc_s    enc;
   wire  [2:0]  pins = {irq_o, home_req_o, motion_en_o};
   int          error_cnt = 0, total_checks = 0;
   apt_servo_model MDL (.clk_sys_i(clk_sys_i), .pos_i(pos), .power_i(pw_on), .bad_fb_i(bad),
      .enc_valid_o(ev), .enc_o(enc), .fb_pos_o(fb), .in_position_o(inp));
   apt_tracker #(.CHECK_CYCLES(50)) DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .enc_valid_i(ev), .enc_i(enc), .fb_pos_i(fb),
      .in_position_i(inp), .amp_power_i(pw_on), .battery_err_i(lost[1]), .battery_removed_i(lost[0]),
      .enc_replaced_i(lost[2]), .servo_cmd_o(servo_cmd_o), .motion_en_o(motion_en_o),
      .home_req_o(home_req_o), .irq_o(irq_o));
   always #12.5 clk_sys_i = ~clk_sys_i;
   // ---------------------------------------------
   // Tasks and expectations
   // ---------------------------------------------
   function automatic logic [31:0] rest_exp(input logic [31:0] h, p, r);
      return h + p - r;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   // Request held until pready is seen at a rising edge; one idle edge follows
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_sys_i);
      pen <= 1'b1;
      @(posedge clk_sys_i);
      while (pready_o !== 1'b1 && n < 20) begin
         @(posedge clk_sys_i);
         n++;
      end
      if (n == 20) begin
         error_cnt++;
         print_verdict();
      end
      q = prdata_o;
      perr = pslverr_o;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      apb(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      apb(1'b0, a, 32'h0, q);
      chk($sformatf("reg %h", a), e, q & m);
   endtask
   task automatic wt(input int s, input logic v);
      for (int i = 0; i < 300 && pins[s] !== v; i++) @(posedge clk_sys_i);
      chk($sformatf("pin %0d", s), {31'h0, v}, {31'h0, pins[s]});
   endtask
   task automatic power(input logic v);
      @(posedge clk_sys_i);
      pw_on <= v;
      wt(0, v);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   initial begin
      #(25 * 20000);
      error_cnt++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h220a));
      ha = $urandom & 32'h00ff_ffff;
      cmd = $urandom & 32'h000f_ffff;
      repeat (20) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      wt(1, 1'b1);
      rdc(`APT_OFF_HIST_CNT, 32'hff, 32'h1);
      rdc(8'h4c, 32'hffff_ffff, 32'h0);
      chk("slverr", 32'h1, {31'h0, perr});
      wr(`APT_OFF_IRQ_EN, 32'h3f);
      wr(`APT_OFF_CLK_DATA, 32'h0c1f_173b);
      wr(`APT_OFF_CTRL, 32'h2);
      power(1'b1);
      rdc(`APT_OFF_IRQ_STAT, 32'h8, 32'h8);
      wt(2, 1'b1);
      wr(`APT_OFF_HIST_SEL, 32'h1);
      rdc(`APT_OFF_HIST_INFO, 32'h3ff, 32'h201);
      wr(`APT_OFF_IRQ_CLR, 32'h3f);
      rdc(`APT_OFF_IRQ_STAT, 32'h3f, 32'h0);
      wt(2, 1'b0);
      wr(`APT_OFF_HOME_ADDR, ha);
      wr(`APT_OFF_CTRL, 32'h1);
      wt(1, 1'b0);
      wr(`APT_OFF_IRQ_CLR, 32'h3f);
      rf = pos;
      rdc(`APT_OFF_FEED, 32'hffff_ffff, ha);
      wr(`APT_OFF_HIST_SEL, 32'h2);
      rdc(`APT_OFF_HIST_ENC, 32'hffff_ffff, rf);
      rdc(`APT_OFF_HIST_INFO, 32'h300, 32'h300);
      rdc(`APT_OFF_HIST_STAMP, 32'hffff_ffff, 32'h0c1f_173b);
      wr(`APT_OFF_POS_CMD, cmd);
      chk("servo_cmd", cmd - ha + rf, servo_cmd_o);
      repeat (60) begin
         @(posedge clk_sys_i);
         pos <= pos + ($urandom & 32'hff);
      end
      rdc(`APT_OFF_IRQ_STAT, 32'h3f, 32'h0);
      rdc(`APT_OFF_MONITOR, 32'hffff_ffff, rest_exp(ha, pos, rf));
      wr(`APT_OFF_CUR_CHG, 32'h0123_4567);
      power(1'b0);
      pos <= pos + 32'h100;
      power(1'b1);
      rdc(`APT_OFF_FEED, 32'hffff_ffff, rest_exp(ha, pos, rf));
      wr(`APT_OFF_HIST_SEL, 32'h3);
      rdc(`APT_OFF_HIST_SCMD, 32'hffff_ffff, cmd - ha + rf);
      rdc(`APT_OFF_HIST_CNT, 32'hff, 32'h5);
      @(posedge clk_sys_i);
      pos <= pos + 32'h0001_0000;
      wt(2, 1'b1);
      rdc(`APT_OFF_IRQ_STAT, 32'h1, 32'h1);
      repeat (60) @(posedge clk_sys_i);
      wr(`APT_OFF_IRQ_CLR, 32'h3f);
      wt(2, 1'b0);
      bad <= 1'b1;
      wt(2, 1'b1);
      rdc(`APT_OFF_IRQ_STAT, 32'h2, 32'h2);
      for (int i = 0; i < 3; i++) begin
         lost <= {lost[1:0], 1'b1};
         wt(1, 1'b1);
         rdc(`APT_OFF_IRQ_STAT, 32'h20, 32'h20);
         wr(`APT_OFF_IRQ_CLR, 32'h20);
         wr(`APT_OFF_CTRL, 32'h1);
         wt(1, 1'b0);
      end
      wr(`APT_OFF_TRAV_LIM, 32'h100);
      wr(`APT_OFF_CTRL, 32'h8);
      power(1'b0);
      pos <= pos + 32'h200;
      power(1'b1);
      wt(1, 1'b1);
      rdc(`APT_OFF_IRQ_STAT, 32'h4, 32'h4);
      wr(`APT_OFF_CTRL, 32'hc);
      rdc(`APT_OFF_CTRL, 32'hc, 32'h4);
      print_verdict();
   end
endmodule
